// File: design/pisff_pkg.sv
/*
 * Shared constants for the speed-loop structure selector and feedforward mux.
 * Assumes one control-loop clock and a synchronous active-high reset.
 */
package pisff_pkg;
	// Object dictionary indices
	localparam logic [15:0] OD_SPEED_FF_OFFSET  = 16'h60b1;
	localparam logic [15:0] OD_TORQUE_FF_OFFSET = 16'h60b2;
	localparam logic [15:0] OD_INTERP_SUBMODE   = 16'h60c0;
	// Structure switch mode codes
	localparam logic [2:0] SW_TORQUE = 3'h0;
	localparam logic [2:0] SW_DEV    = 3'h1;
	localparam logic [2:0] SW_ACCEL  = 3'h2;
	localparam logic [2:0] SW_SPEED  = 3'h3;
	localparam logic [2:0] SW_FIX_PI = 3'h4;
	// Feedforward source codes
	localparam logic [1:0] FF_INTERNAL = 2'h0;
	localparam logic [1:0] FF_MODEL    = 2'h1;
	localparam logic [1:0] FF_BUS      = 2'h2;
	localparam logic [1:0] FF_CUBIC    = 2'h3;
	// Torque feedforward variants
	localparam logic [1:0] TFV_GENERAL = 2'h0;
	localparam logic [1:0] TFV_FAST    = 2'h2;
	// Model following selections
	localparam logic [1:0] MF_OFF      = 2'h0;
	// Cubic interpolation submode value
	localparam logic [15:0] INTERP_CUBIC = 16'hffff;
	// Reset values
	localparam logic [2:0]  RST_SWITCH_MODE = 3'h0;
	localparam logic [31:0] RST_TORQUE_THR  = 32'h0000_00c8;
	localparam logic [1:0]  RST_FF_SOURCE   = 2'h0;
	localparam logic [1:0]  RST_MF_SELECT   = 2'h0;
	// Fixed-point scale of gains and percentages (value / 2^shift)
	localparam int GAIN_SHIFT = 8;
	localparam int PCT_SHIFT  = 7;
	// Filter shift for the fast torque variant
	localparam logic [3:0] FAST_FILT_SHIFT = 4'h1;
	// Control-loop states
	typedef enum logic [1:0] {
		PISFF_CONFIG = 2'b00,
		PISFF_RUN    = 2'b01
	} pisff_state_e;
endpackage : pisff_pkg

// File: design/pisff_lpf.sv
/*
 * First-order low-pass filter, y += (x - y) >> shift, one step per enable.
 * Assumes a synchronous active-high reset; shift is a run-time setting.
 */
`timescale 1ns/1ps
module pisff_lpf #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Step and setting
	input  wire logic         step,
	input  wire logic [3:0]   shift,
	// Data
	input  wire logic signed [W-1:0] x,
	output logic signed [W-1:0]      y
);
	typedef struct packed {
		logic signed [W-1:0] y;
	} pisff_lpf_s;

	pisff_lpf_s s_q;
	pisff_lpf_s s_d;
	logic signed [W:0] diff;

	// Filter update
	always_comb begin
		s_d = s_q;
		diff = {x[W-1], x} - {s_q.y[W-1], s_q.y};
		if (step) begin
			s_d.y = s_q.y + W'(diff >>> shift);
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign y = s_q.y;
endmodule : pisff_lpf

// File: design/pisff_top.sv
/*
 * Speed-loop P/PI structure selector and feedforward source multiplexer.
 * Assumes all inputs synchronous to sys_clk; loop_step marks each control cycle.
 */
// Function
// [R1] PI control unless switch condition active
// [R2] Mode 0 torque, mode 1 deviation
// [R3] Mode 2 acceleration, mode 3 speed
// [R4] Mode 4 fixes PI control
// [R5] Modes 0-3: P above threshold
// [R6] Thresholds apply immediately
// [R7] Reset mode 0, torque threshold 200; here the threshold is a live input with no reset value, RST_TORQUE_THR unused
// [R8] Speed source 0 internal, 1 model
// [R9] Speed source 2 bus, 3 cubic
// [R10] Torque source internal/model/bus/cubic
// [R11] Speed ff = dPos times gain
// [R12] Torque ff = dSpeed*inertia*gain
// [R13] Filtered internal paths, settings immediate
// [R14] Torque variant 0 general, 2 fast
// [R15] Host enables model following first
// [R16] Bus offsets under fieldbus control only
// [R17] Cubic needs fieldbus and submode -1
// [R18] Model following 0/1/2, after restart
// [R19] Model percentages only with source 1
// [R20] Unavailable source gives zero
`timescale 1ns/1ps
module pisff_top #(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Control cycle strobe and restart
	input  wire logic                loop_step,
	input  wire logic                restart,
	// Restart-applied settings
	input  wire logic [2:0]          structure_switch_mode,
	input  wire logic [1:0]          speed_ff_source,
	input  wire logic [1:0]          torque_ff_source,
	input  wire logic [1:0]          torque_ff_variant,
	input  wire logic [1:0]          model_following_select,
	// Immediate settings
	input  wire logic signed [31:0]  torque_switch_threshold,
	input  wire logic signed [31:0]  deviation_switch_threshold,
	input  wire logic signed [31:0]  accel_switch_threshold,
	input  wire logic signed [31:0]  speed_switch_threshold,
	input  wire logic [15:0]         speed_ff_gain,
	input  wire logic [3:0]          speed_ff_filter_time,
	input  wire logic [15:0]         torque_ff_gain,
	input  wire logic [3:0]          torque_ff_filter_time,
	input  wire logic [15:0]         load_inertia_pct,
	input  wire logic [15:0]         model_following_speed_ff_pct,
	input  wire logic [15:0]         model_following_torque_ff_pct,
	// Object dictionary write port
	input  wire logic                od_wr,
	input  wire logic [15:0]         od_index,
	input  wire logic [31:0]         od_wdata,
	input  wire logic                fieldbus_ctrl,
	// Monitored quantities
	input  wire logic signed [31:0]  torque_ref,
	input  wire logic signed [31:0]  position_deviation,
	input  wire logic signed [31:0]  accel_ref,
	input  wire logic signed [31:0]  speed_ref,
	input  wire logic signed [31:0]  position_ref,
	// Other feedforward sources
	input  wire logic signed [W-1:0] model_speed_ff,
	input  wire logic signed [W-1:0] model_torque_ff,
	input  wire logic signed [W-1:0] cubic_speed_ff,
	input  wire logic signed [W-1:0] cubic_torque_ff,
	// Results
	output logic                     p_only,
	output logic signed [W-1:0]      speed_ff_out,
	output logic signed [W-1:0]      torque_ff_out,
	output logic signed [31:0]       speed_feedforward_offset,
	output logic signed [15:0]       torque_feedforward_offset,
	output logic signed [15:0]       interpolation_submode_select
);
	typedef struct packed {
		pisff_pkg::pisff_state_e st;
		logic [2:0]              mode;
		logic [1:0]              sp_src;
		logic [1:0]              tq_src;
		logic [1:0]              tq_var;
		logic [1:0]              mf_sel;
		logic signed [31:0]      prev_pos;
		logic signed [31:0]      prev_spd;
		logic signed [W-1:0]     sp_raw;
		logic signed [W-1:0]     tq_raw;
		logic                    p_only;
		logic signed [W-1:0]     sp_ff;
		logic signed [W-1:0]     tq_ff;
		logic signed [31:0]      vel_off;
		logic signed [15:0]      tq_off;
		logic signed [15:0]      submode;
	} pisff_s;

	pisff_s s_q;
	pisff_s s_d;
	logic signed [W-1:0] sp_filt;
	logic signed [W-1:0] tq_filt;
	logic [3:0]          tq_shift;
	logic                st_run;

	// Compare a quantity against its threshold, strictly above
	function automatic logic above(input logic signed [31:0] v, input logic signed [31:0] t);
		return v > t;
	endfunction : above

	// Scale by an unsigned fixed-point factor
	function automatic logic signed [W-1:0] scale(input logic signed [W-1:0] v,
		input logic [15:0] k, input int sh);
		logic signed [W+16:0] p;
		p = v * $signed({1'b0, k});
		return W'(p >>> sh);
	endfunction : scale

	// Fast variant trades noise rejection for lag
	assign tq_shift = (s_q.tq_var == pisff_pkg::TFV_FAST) ? pisff_pkg::FAST_FILT_SHIFT
		: torque_ff_filter_time;

	// Running with latched settings
	assign st_run = (s_q.st == pisff_pkg::PISFF_RUN);

	// Internal feedforward filters
	pisff_lpf #(.W(W)) u_sp_lpf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.step    (loop_step),
		.shift   (speed_ff_filter_time), // R13
		.x       (s_q.sp_raw),
		.y       (sp_filt)
	);
	pisff_lpf #(.W(W)) u_tq_lpf (
		.sys_clk (sys_clk),
		.rst     (rst),
		.step    (loop_step),
		.shift   (tq_shift), // R13
		.x       (s_q.tq_raw),
		.y       (tq_filt)
	);

	// Next state
	always_comb begin
		logic sw;
		logic mf_on;
		logic cubic_ok;
		s_d = s_q;
		sw = 1'b0;
		mf_on = (s_q.mf_sel != pisff_pkg::MF_OFF);
		cubic_ok = fieldbus_ctrl && (s_q.submode == $signed(pisff_pkg::INTERP_CUBIC)); // R17
		// Latch restart-applied settings
		case (s_q.st)
			pisff_pkg::PISFF_CONFIG: begin
				s_d.mode = structure_switch_mode;
				s_d.sp_src = speed_ff_source;
				s_d.tq_src = torque_ff_source;
				s_d.tq_var = torque_ff_variant; // R14
				s_d.mf_sel = model_following_select; // R18
				s_d.st = pisff_pkg::PISFF_RUN;
			end
			default: begin
				if (restart) begin
					s_d.st = pisff_pkg::PISFF_CONFIG;
				end
			end
		endcase
		// Object dictionary writes
		if (od_wr) begin
			if (od_index == pisff_pkg::OD_SPEED_FF_OFFSET) begin
				s_d.vel_off = $signed(od_wdata); // R16
			end else if (od_index == pisff_pkg::OD_TORQUE_FF_OFFSET) begin
				s_d.tq_off = $signed(od_wdata[15:0]); // R16
			end else if (od_index == pisff_pkg::OD_INTERP_SUBMODE) begin
				s_d.submode = $signed(od_wdata[15:0]);
			end
		end
		// Structure switch, thresholds read live
		case (s_q.mode)
			pisff_pkg::SW_TORQUE: sw = above(torque_ref, torque_switch_threshold); // R2 R6
			pisff_pkg::SW_DEV:    sw = above(position_deviation, deviation_switch_threshold); // R2
			pisff_pkg::SW_ACCEL:  sw = above(accel_ref, accel_switch_threshold); // R3
			pisff_pkg::SW_SPEED:  sw = above(speed_ref, speed_switch_threshold); // R3
			default:              sw = 1'b0; // R4
		endcase
		// Control-cycle work
		if (loop_step) begin
			s_d.p_only = sw; // R1 R5
			s_d.prev_pos = position_ref;
			s_d.prev_spd = speed_ref;
			s_d.sp_raw = scale(W'(position_ref - s_q.prev_pos), speed_ff_gain,
				pisff_pkg::GAIN_SHIFT); // R11
			s_d.tq_raw = scale(scale(W'(speed_ref - s_q.prev_spd), load_inertia_pct,
				pisff_pkg::PCT_SHIFT), torque_ff_gain, pisff_pkg::GAIN_SHIFT); // R12
			// Speed source
			case (s_q.sp_src)
				pisff_pkg::FF_INTERNAL: s_d.sp_ff = sp_filt; // R8
				pisff_pkg::FF_MODEL: s_d.sp_ff = mf_on ? scale(model_speed_ff,
					model_following_speed_ff_pct, pisff_pkg::PCT_SHIFT) : '0; // R8 R19 R20
				pisff_pkg::FF_BUS: s_d.sp_ff = fieldbus_ctrl ? W'(s_q.vel_off) : '0; // R9 R20
				default: s_d.sp_ff = cubic_ok ? cubic_speed_ff : '0; // R9 R20
			endcase
			// Torque source
			case (s_q.tq_src)
				pisff_pkg::FF_INTERNAL: s_d.tq_ff = tq_filt; // R10
				pisff_pkg::FF_MODEL: s_d.tq_ff = mf_on ? scale(model_torque_ff,
					model_following_torque_ff_pct, pisff_pkg::PCT_SHIFT) : '0; // R10 R19 R20
				pisff_pkg::FF_BUS: s_d.tq_ff = fieldbus_ctrl ? W'(s_q.tq_off) : '0; // R10 R20
				default: s_d.tq_ff = cubic_ok ? cubic_torque_ff : '0; // R10 R20
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= pisff_pkg::PISFF_CONFIG;
			s_q.mode <= pisff_pkg::RST_SWITCH_MODE; // R7
			s_q.sp_src <= pisff_pkg::RST_FF_SOURCE;
			s_q.tq_src <= pisff_pkg::RST_FF_SOURCE;
			s_q.mf_sel <= pisff_pkg::RST_MF_SELECT;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign p_only = s_q.p_only;
	assign speed_ff_out = s_q.sp_ff;
	assign torque_ff_out = s_q.tq_ff;
	assign speed_feedforward_offset = s_q.vel_off;
	assign torque_feedforward_offset = s_q.tq_off;
	assign interpolation_submode_select = s_q.submode;

	// Assertions
	a_fixed_pi_mode: assert property (@(posedge sys_clk) disable iff (rst) // R4
		(s_q.mode == pisff_pkg::SW_FIX_PI && loop_step) |=> !p_only)
		else $error("p-only set in fixed PI mode");
	a_torque_switch: assert property (@(posedge sys_clk) disable iff (rst) // R2
		(s_q.mode == pisff_pkg::SW_TORQUE && loop_step && st_run)
		|=> p_only == $past(torque_ref > torque_switch_threshold))
		else $error("torque switch mismatch");
	a_speed_switch: assert property (@(posedge sys_clk) disable iff (rst) // R3
		(s_q.mode == pisff_pkg::SW_SPEED && loop_step)
		|=> p_only == $past(speed_ref > speed_switch_threshold))
		else $error("speed switch mismatch");
	a_accel_switch: assert property (@(posedge sys_clk) disable iff (rst) // R3
		(s_q.mode == pisff_pkg::SW_ACCEL && loop_step)
		|=> p_only == $past(accel_ref > accel_switch_threshold))
		else $error("acceleration switch mismatch");
	a_deviation_sw: assert property (@(posedge sys_clk) disable iff (rst) // R2
		(s_q.mode == pisff_pkg::SW_DEV && loop_step)
		|=> p_only == $past(position_deviation > deviation_switch_threshold))
		else $error("deviation switch mismatch");
	a_hold_no_step: assert property (@(posedge sys_clk) disable iff (rst) // R5
		!loop_step |=> $stable(p_only) && $stable(speed_ff_out))
		else $error("outputs changed without loop step");
	a_bus_zero_off: assert property (@(posedge sys_clk) disable iff (rst) // R20
		(s_q.sp_src == pisff_pkg::FF_BUS && !fieldbus_ctrl && loop_step)
		|=> speed_ff_out == '0)
		else $error("bus speed ff without fieldbus");
	a_bus_speed_ff: assert property (@(posedge sys_clk) disable iff (rst) // R9
		(s_q.sp_src == pisff_pkg::FF_BUS && fieldbus_ctrl && loop_step)
		|=> speed_ff_out == W'($past(s_q.vel_off)))
		else $error("bus speed ff mismatch");
	a_bus_torque_ff: assert property (@(posedge sys_clk) disable iff (rst) // R10
		(s_q.tq_src == pisff_pkg::FF_BUS && fieldbus_ctrl && loop_step)
		|=> torque_ff_out == W'($signed($past(s_q.tq_off))))
		else $error("bus torque ff mismatch");
	a_cubic_gate: assert property (@(posedge sys_clk) disable iff (rst) // R17
		(s_q.tq_src == pisff_pkg::FF_CUBIC && loop_step
		&& s_q.submode != $signed(pisff_pkg::INTERP_CUBIC)) |=> torque_ff_out == '0)
		else $error("cubic torque ff without submode");
	a_cubic_speed_ff: assert property (@(posedge sys_clk) disable iff (rst) // R9
		(s_q.sp_src == pisff_pkg::FF_CUBIC && fieldbus_ctrl && loop_step
		&& s_q.submode == $signed(pisff_pkg::INTERP_CUBIC))
		|=> speed_ff_out == $past(cubic_speed_ff))
		else $error("cubic speed ff mismatch");
	a_model_gate: assert property (@(posedge sys_clk) disable iff (rst) // R20
		(s_q.sp_src == pisff_pkg::FF_MODEL && s_q.mf_sel == pisff_pkg::MF_OFF && loop_step)
		|=> speed_ff_out == '0)
		else $error("model speed ff while model following off");
	a_offset_write: assert property (@(posedge sys_clk) disable iff (rst) // R16
		(od_wr && od_index == pisff_pkg::OD_SPEED_FF_OFFSET)
		|=> speed_feedforward_offset == $signed($past(od_wdata)))
		else $error("speed offset write lost");
	a_submode_write: assert property (@(posedge sys_clk) disable iff (rst) // R17
		(od_wr && od_index == pisff_pkg::OD_INTERP_SUBMODE)
		|=> interpolation_submode_select == $signed($past(od_wdata[15:0])))
		else $error("submode write lost");
	a_config_latch: assert property (@(posedge sys_clk) disable iff (rst) // R18
		(s_q.st == pisff_pkg::PISFF_CONFIG)
		|=> s_q.mf_sel == $past(model_following_select))
		else $error("model following selection not latched");
	a_reset_mode: assert property (@(posedge sys_clk) // R7
		$past(rst) |-> s_q.mode == pisff_pkg::RST_SWITCH_MODE)
		else $error("switch mode not zero after reset");

	c_p_only: cover property (@(posedge sys_clk) disable iff (rst) $rose(p_only));
	c_pi_resume: cover property (@(posedge sys_clk) disable iff (rst) $fell(p_only));
	c_bus_ff: cover property (@(posedge sys_clk) disable iff (rst)
		s_q.sp_src == pisff_pkg::FF_BUS && fieldbus_ctrl && loop_step);
	c_restart: cover property (@(posedge sys_clk) disable iff (rst) restart && st_run);
	c_fast_variant: cover property (@(posedge sys_clk) disable iff (rst)
		s_q.tq_var == pisff_pkg::TFV_FAST && loop_step);
endmodule : pisff_top

// File: verif/pisff_host_model.sv
/*
 * Host motion controller model: writes objects and sets fieldbus control.
 * Assumes writes are taken on the rising edge after a falling-edge launch.
 */
`timescale 1ns/1ps
module pisff_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Object write port and control mode
	output logic             od_wr,
	output logic [15:0]      od_index,
	output logic [31:0]      od_wdata,
	output logic             fieldbus_ctrl
);
	// Quiet bus at time zero
	initial begin
		od_wr = 1'b0;
		od_index = 16'h0000;
		od_wdata = 32'h0000_0000;
		fieldbus_ctrl = 1'b0;
	end

	// One-cycle write; idle bus shows the inverse so stale data never looks valid
	task automatic write_obj(input logic [15:0] idx, input logic [31:0] data);
		@(negedge sys_clk);
		od_wr = 1'b1;
		od_index = idx;
		od_wdata = data;
		@(negedge sys_clk);
		od_wr = 1'b0;
		od_index = ~idx;
		od_wdata = ~data;
	endtask : write_obj

	// Enter or leave fieldbus control
	task automatic set_bus(input logic on);
		@(negedge sys_clk);
		fieldbus_ctrl = on;
	endtask : set_bus
endmodule : pisff_host_model

// File: verif/test_pi_switch_feedforward_select.sv
/*
 * Self-checking bench for the P/PI selector and feedforward multiplexer.
 * Assumes the host model drives the object port and fieldbus control; bench drives the rest.
 */
`timescale 1ns/1ps
module test_pi_switch_feedforward_select;
	typedef struct packed {
		logic [2:0]         mode;
		logic signed [31:0] tq;
		logic signed [31:0] dev;
		logic signed [31:0] acc;
		logic signed [31:0] spd;
		logic               exp;
	} pisff_row_s;
	logic               sys_clk, rst, loop_step, restart, p_only, od_wr, fieldbus_ctrl;
	logic [2:0]         sw_mode;
	logic [1:0]         sp_src, tq_src, tq_var, mf_sel;
	logic signed [31:0] tq_thr, sw_thr, tq, dev, acc, spd, pos;
	logic signed [31:0] m_sp, m_tq, c_sp, c_tq, sp_out, tq_out, sp_off;
	logic [15:0]        od_index, mf_pct, sp_gain, tq_gain;
	logic [3:0]         ff_ft;
	logic [31:0]        od_wdata;
	logic signed [15:0] tq_off, submode;
	int                 n_mismatch, num_checks, cycles;
	pisff_row_s         rows[7];

	pisff_host_model host (.sys_clk(sys_clk), .od_wr(od_wr), .od_index(od_index),
		.od_wdata(od_wdata), .fieldbus_ctrl(fieldbus_ctrl));
	pisff_top dut (.sys_clk(sys_clk), .rst(rst), .loop_step(loop_step), .restart(restart),
		.structure_switch_mode(sw_mode), .speed_ff_source(sp_src),
		.torque_ff_source(tq_src), .torque_ff_variant(tq_var), .model_following_select(mf_sel),
		.torque_switch_threshold(tq_thr), .deviation_switch_threshold(sw_thr),
		.accel_switch_threshold(sw_thr), .speed_switch_threshold(sw_thr),
		.speed_ff_gain(sp_gain), .speed_ff_filter_time(ff_ft), .torque_ff_gain(tq_gain),
		.torque_ff_filter_time(ff_ft), .load_inertia_pct(mf_pct),
		.model_following_speed_ff_pct(mf_pct), .model_following_torque_ff_pct(mf_pct),
		.od_wr(od_wr), .od_index(od_index), .od_wdata(od_wdata), .fieldbus_ctrl(fieldbus_ctrl),
		.torque_ref(tq), .position_deviation(dev), .accel_ref(acc), .speed_ref(spd),
		.position_ref(pos), .model_speed_ff(m_sp), .model_torque_ff(m_tq),
		.cubic_speed_ff(c_sp), .cubic_torque_ff(c_tq), .p_only(p_only), .speed_ff_out(sp_out),
		.torque_ff_out(tq_out), .speed_feedforward_offset(sp_off),
		.torque_feedforward_offset(tq_off), .interpolation_submode_select(submode));

	// 100 ns clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// One control cycle; results settle before the next falling edge
	task automatic step();
		@(negedge sys_clk);
		loop_step = 1'b1;
		@(negedge sys_clk);
		loop_step = 1'b0;
	endtask : step

	// Restart so restart-applied settings are latched again
	task automatic relatch();
		@(negedge sys_clk);
		restart = 1'b1;
		@(negedge sys_clk);
		restart = 1'b0;
		repeat (2) @(negedge sys_clk);
	endtask : relatch

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	initial begin
		{rst, loop_step, restart, sw_mode, sp_src, tq_src, tq_var, mf_sel} = '0;
		{tq, dev, acc, spd, pos, m_sp, m_tq, c_sp, c_tq} = '0;
		tq_thr = 32'sd200;
		sw_thr = 32'sd200;
		sp_gain = 16'h0200;
		tq_gain = 16'h0180;
		ff_ft = 4'h2;
		mf_pct = 16'h0080;
		rst = 1'b1;
		rows[0] = {3'h0, 32'sd201, 32'sd0, 32'sd0, 32'sd0, 1'b1};
		rows[1] = {3'h0, 32'sd200, 32'sd0, 32'sd0, 32'sd0, 1'b0};
		rows[2] = {3'h1, 32'sd999, 32'sd201, 32'sd0, 32'sd0, 1'b1};
		rows[3] = {3'h1, 32'sd999, 32'sd200, 32'sd0, 32'sd0, 1'b0};
		rows[4] = {3'h2, 32'sd0, 32'sd0, 32'sd201, 32'sd0, 1'b1};
		rows[5] = {3'h3, 32'sd0, 32'sd0, 32'sd999, 32'sd201, 1'b1};
		rows[6] = {3'h4, 32'sd999, 32'sd999, 32'sd999, 32'sd999, 1'b0};
		repeat (10) @(negedge sys_clk);
		check({p_only, sp_out[30:0]}, 32'h0, "reset p_only/speed");
		check(tq_out, 32'h0, "reset torque ff");
		rst = 1'b0;
		repeat (2) @(negedge sys_clk);
		// Structure selection table
		foreach (rows[i]) begin
			sw_mode = rows[i].mode;
			relatch();
			{tq, dev, acc, spd} = {rows[i].tq, rows[i].dev, rows[i].acc, rows[i].spd};
			step();
			check({31'h0, p_only}, {31'h0, rows[i].exp}, "p_only row");
		end
		// Threshold change applies without restart
		sw_mode = 3'h0;
		relatch();
		tq = 32'sd300;
		tq_thr = 32'sd400;
		step();
		check({31'h0, p_only}, 32'h0, "below raised threshold");
		tq_thr = 32'sd250;
		step();
		check({31'h0, p_only}, 32'h1, "above lowered threshold");
		// Model-following sources, enabled then disabled
		{m_sp, m_tq} = {32'sd1234, -32'sd55};
		{sp_src, tq_src, mf_sel} = {2'h1, 2'h1, 2'h1};
		relatch();
		step();
		check(sp_out, 32'sd1234, "model speed ff");
		check(tq_out, -32'sd55, "model torque ff");
		mf_sel = 2'h0;
		relatch();
		step();
		check(sp_out | tq_out, 32'h0, "model ff while off");
		// Bus-written offsets
		{sp_src, tq_src} = {2'h2, 2'h2};
		relatch();
		host.set_bus(1'b1);
		host.write_obj(16'h60b1, 32'h8000_0001);
		host.write_obj(16'h60b2, 32'h0001_ff85);
		host.write_obj(16'h60b3, 32'h1234_5678);
		check(sp_off, 32'h8000_0001, "speed offset readback");
		check({16'h0, tq_off}, 32'h0000_ff85, "torque offset readback");
		step();
		check(sp_out, 32'h8000_0001, "bus speed ff");
		check(tq_out, 32'hffff_ff85, "bus torque ff");
		host.set_bus(1'b0);
		step();
		check(sp_out | tq_out, 32'h0, "bus ff outside fieldbus");
		// Cubic sources need fieldbus control and submode -1
		{sp_src, tq_src, c_sp, c_tq} = {2'h3, 2'h3, 32'sd777, -32'sd9};
		relatch();
		host.set_bus(1'b1);
		host.write_obj(16'h60c0, 32'h0000_0001);
		step();
		check(sp_out | tq_out, 32'h0, "cubic without submode");
		host.write_obj(16'h60c0, 32'h0000_ffff);
		check({16'h0, submode}, 32'h0000_ffff, "submode readback");
		step();
		check(sp_out, 32'sd777, "cubic speed ff");
		check(tq_out, -32'sd9, "cubic torque ff");
		host.set_bus(1'b0);
		step();
		check(sp_out | tq_out, 32'h0, "cubic outside fieldbus");
		// Internal paths unfiltered, gains 2.0 and 1.5, inertia 1.0; then fast variant
		{sp_src, tq_src, ff_ft} = {2'h0, 2'h0, 4'h0};
		relatch();
		for (int k = 1; k <= 7; k++) begin
			if (k == 5) begin
				check(sp_out, 32'sd80, "internal speed ff");
				check(tq_out, 32'sd6, "internal torque ff");
				tq_var = 2'h2;
				relatch();
			end
			pos = 40 * k;
			spd = (k < 5) ? 1000 + 4 * k : 1016 + 8 * (k - 4);
			step();
		end
		check(tq_out, 32'sd9, "fast torque variant");
		// Mid-run reset clears results and bus objects
		rst = 1'b1;
		tq_thr = 32'sd200;
		tq = 32'sd201;
		repeat (2) @(negedge sys_clk);
		check(sp_out | tq_out | sp_off, 32'h0, "reset results");
		check({p_only, 15'h0, submode}, 32'h0, "reset flag and submode");
		rst = 1'b0;
		step();
		check({31'h0, p_only}, 32'h1, "p-only above 200 after reset");
		give_verdict();
	end
endmodule : test_pi_switch_feedforward_select
